// *** design/bpwm_pkg.sv ***
/*
  Package of the bidirectional PWM clock and protection block: register map,
  reset values, timing figures, comparator bundle and state encodings.
  Assumes a single 100 MHz clock and a classic Wishbone slave port.
*/
package bpwm_pkg;

  // Register byte offsets on the 32-bit Wishbone bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DUTY = 8'h04;
  localparam logic [7:0] OFF_PHASE = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;

  // Field widths and positions.
  localparam int PER_W = 12;
  localparam int PCT_W = 7;
  localparam int EVT_W = 5;
  localparam int DUTY_CMD_LSB = 0;
  localparam int DUTY_CEIL_LSB = 8;

  // Event bit positions in the interrupt registers.
  localparam int EVT_FAULT = 0;
  localparam int EVT_OVERTEMP = 1;
  localparam int EVT_NEG = 2;
  localparam int EVT_PEAK = 3;
  localparam int EVT_ROLE = 4;

  // Switching rate limits, with period counts derived from the clock rate.
  localparam longint CLK_HZ = 100000000;
  localparam longint F_MIN_HZ = 50000;
  localparam longint F_MAX_HZ = 300000;
  localparam logic [PER_W-1:0] PER_MAX = PER_W'(CLK_HZ / F_MIN_HZ);
  localparam logic [PER_W-1:0] PER_MIN = PER_W'((CLK_HZ + F_MAX_HZ - 1) / F_MAX_HZ);

  // Duty ceiling and percent scale.
  localparam logic [PCT_W-1:0] DUTY_MAX_PCT = 7'h61;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

  // Reset values.
  localparam logic [PER_W-1:0] RST_PERIOD = 12'h3e8;
  localparam logic [PCT_W-1:0] RST_CMD = 7'h00;
  localparam logic [PCT_W-1:0] RST_CEIL = 7'h7f;
  localparam logic [PER_W-1:0] RST_PHASE = 12'h000;
  localparam logic [EVT_W-1:0] RST_EVT = 5'h00;

  // Comparator results coming from the analog front end, one bit each.
  typedef struct packed {
    logic en_ok;
    logic role_hi;
    logic role_lo;
    logic fault_ok;
    logic ot_trip;
    logic ot_cool;
    logic mode_high;
    logic neg_valley;
    logic peak_lim;
    logic sync_in;
  } bpwm_cmp_s;

  // Drive outputs towards the half-bridge gate driver.
  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } bpwm_drive_s;

  typedef enum logic [2:0] {
    ROLE_MASTER = 3'b001,
    ROLE_SLAVE = 3'b010,
    ROLE_SHIFT = 3'b100
  } bpwm_role_e;

  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } bpwm_state_e;

endpackage

// *** design/bpwm_ctrl.sv ***
/*
  Switching clock selection and protection logic of a bidirectional buck/boost
  PWM controller, with a classic Wishbone register slave and one interrupt.
  Assumes all comparator inputs are asynchronous, the SYNC pin is open drain
  with an external pull-up, and CLOCK runs at 100 MHz.
*/
// Summary of operation
// R1: In buck, a negative valley comparator result drops the low-side drive immediately.
// R2: Switching period is programmable, clamped between the 50 kHz and 300 kHz settings.
// R3: Role input high or floating makes us master, driving our clock out open drain.
// R4: The master clock on the sync pin has equal high and low halves.
// R5: Role input low makes the sync pin an input and we follow it in phase.
// R6: Intermediate role input follows the external clock delayed by a programmed shift.
// R7: Duty ceiling programmable up to 97 percent, defaulting to 97 when out of range.
// R8: While fault input is low, both drives are low and soft start is discharged.
// R9: When the fault input returns high, switching resumes.
// R10: Over-temperature stops switching, drives low, discharges soft start; supply stays up.
// R11: Over-temperature clears at the lower hysteresis point and the loop restarts.
// R12: Mode input low selects boost, high selects buck.
// R13: Mode may change only while shut down, faulted, over-temperature or under-voltage.
// R14: Limit threshold selection follows the mode: buck peak plus valley, boost higher peak.
// R15: The peak current limit acts identically in buck and boost.
// R16: A slave's free-running rate should be near but not equal to the supplied clock.
// R17: Mode is captured on the fault rising edge and held until next disable.
// R18: Every analog comparator result is synchronised before the logic uses it.
// R19: A role change takes effect only at the next switching period boundary.
module bpwm_ctrl
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire bpwm_pkg::bpwm_cmp_s CMP_IN,
  output logic SYNC_O,
  output logic SYNC_OE,
  output bpwm_pkg::bpwm_drive_s DRIVE,
  output logic SS_DISCHARGE,
  output logic BOOST_THRESH_SEL,
  output logic IRQ
);
  import bpwm_pkg::*;

  // State of the block. Every flop below freezes while CE is low, so a paused
  // clock enable stretches the switching period rather than corrupting it.
  // The drive outputs and the sync pin enable are registered so that they
  // can never glitch while the decode logic settles.
  bpwm_cmp_s cmp_s1_q;
  bpwm_cmp_s cmp_q;
  logic sync_prev_q;
  logic fault_prev_q;
  logic [PER_W-1:0] rate_q;
  logic [PCT_W-1:0] cmd_q;
  logic [PCT_W-1:0] ceil_q;
  logic [PER_W-1:0] phase_q;
  logic [EVT_W-1:0] stat_q;
  logic [EVT_W-1:0] irq_en_q;
  logic ack_q;
  logic [31:0] rdata_q;
  bpwm_state_e state_q;
  logic buck_q;
  logic ot_q;
  bpwm_role_e role_q;
  bpwm_role_e role_sel;
  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] dly_q;
  logic dly_run_q;
  logic peak_cut_q;
  bpwm_drive_s drive_q;
  logic sync_oe_q;

  // Clamps a requested period to the legal switching range.
  function automatic logic [PER_W-1:0] clamp_period(input logic [PER_W-1:0] p);
    logic [PER_W-1:0] r;
    r = p;
    if (p < PER_MIN)
    begin
      r = PER_MIN;
    end
    else if (p > PER_MAX)
    begin
      r = PER_MAX;
    end
    return r;
  endfunction

  // Limits a percentage to the internal maximum duty.
  function automatic logic [PCT_W-1:0] clamp_pct(input logic [PCT_W-1:0] p);
    return (p > DUTY_MAX_PCT) ? DUTY_MAX_PCT : p;
  endfunction

  // Two-stage synchroniser on every comparator result and the sync pin.
  // The comparators switch at any time, so only the second stage may be read
  // by logic; the first stage may go metastable and is never used elsewhere.
  // This adds two cycles of latency to every protection response.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      cmp_s1_q <= '0;
      cmp_q <= '0;
    end
    else if (CE)
    begin
      cmp_s1_q <= CMP_IN; // [R18]
      cmp_q <= cmp_s1_q; // [R18]
    end
  end

  // Bus decode and register selection.
  // A request is taken only while no acknowledge is pending, so a master that
  // keeps its strobe high for one extra cycle is not served twice.
  // Unmapped addresses read as zero and ignore writes.
  wire bus_req = WB_CYC_I && WB_STB_I && !ack_q;
  wire bus_wr = bus_req && WB_WE_I;
  wire wr_ctrl = bus_wr && (WB_ADR_I == OFF_CTRL);
  wire wr_duty = bus_wr && (WB_ADR_I == OFF_DUTY);
  wire wr_phase = bus_wr && (WB_ADR_I == OFF_PHASE);
  wire wr_clr = bus_wr && (WB_ADR_I == OFF_IRQ_CLR) && WB_SEL_I[0];
  wire wr_en = bus_wr && (WB_ADR_I == OFF_IRQ_EN) && WB_SEL_I[0];
  wire [PCT_W-1:0] ceil_eff = clamp_pct(ceil_q); // [R7]
  wire [PCT_W-1:0] cmd_eff = (cmd_q < ceil_eff) ? cmd_q : ceil_eff; // [R7]
  wire [31:0] state_word = {24'h000000, 1'b0, role_q, ot_q, buck_q, state_q};
  wire [31:0] rd_mux =
    (WB_ADR_I == OFF_CTRL) ? {20'h00000, rate_q} :
    (WB_ADR_I == OFF_DUTY) ? {17'h00000, ceil_q, 1'b0, cmd_q} :
    (WB_ADR_I == OFF_PHASE) ? {20'h00000, phase_q} :
    (WB_ADR_I == OFF_STATE) ? state_word :
    (WB_ADR_I == OFF_IRQ_STAT) ? {27'h0000000, stat_q} :
    (WB_ADR_I == OFF_IRQ_EN) ? {27'h0000000, irq_en_q} : 32'h00000000;

  // Register writes honour byte enables; ack follows one cycle after the request.
  // Read data is registered together with the acknowledge and is zero at all
  // other times. Rate and phase writes take effect only at a period boundary
  // or at the next sync edge, so software may change them while switching.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rate_q <= RST_PERIOD;
      cmd_q <= RST_CMD;
      ceil_q <= RST_CEIL;
      phase_q <= RST_PHASE;
      irq_en_q <= RST_EVT;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else if (CE)
    begin
      ack_q <= bus_req;
      rdata_q <= bus_req ? rd_mux : 32'h00000000;
      if (wr_ctrl && WB_SEL_I[0])
      begin
        rate_q[7:0] <= WB_DAT_I[7:0];
      end
      if (wr_ctrl && WB_SEL_I[1])
      begin
        rate_q[PER_W-1:8] <= WB_DAT_I[PER_W-1:8];
      end
      if (wr_duty && WB_SEL_I[0])
      begin
        cmd_q <= WB_DAT_I[DUTY_CMD_LSB +: PCT_W];
      end
      if (wr_duty && WB_SEL_I[1])
      begin
        ceil_q <= WB_DAT_I[DUTY_CEIL_LSB +: PCT_W];
      end
      if (wr_phase && WB_SEL_I[0])
      begin
        phase_q[7:0] <= WB_DAT_I[7:0];
      end
      if (wr_phase && WB_SEL_I[1])
      begin
        phase_q[PER_W-1:8] <= WB_DAT_I[PER_W-1:8];
      end
      if (wr_en)
      begin
        irq_en_q <= WB_DAT_I[EVT_W-1:0];
      end
    end
  end

  // Enable and protection decode.
  wire run_ok = cmp_q.en_ok && cmp_q.fault_ok && !ot_q; // [R8] [R10]
  wire start_run = (state_q == ST_OFF) && run_ok;
  wire fault_rise = cmp_q.fault_ok && !fault_prev_q;

  // Run state, over-temperature latch with hysteresis and mode capture.
  // The trip comparator wins over the cool comparator, so a noisy sensor near
  // the lower point cannot release the latch while it is still hot.
  // The mode is sampled only while off, when switching starts or the fault
  // input rises, never while running, so a mode input that moves during
  // operation cannot flip the converter.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_OFF;
      ot_q <= 1'b0;
      buck_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end
    else if (CE)
    begin
      fault_prev_q <= cmp_q.fault_ok;
      if (cmp_q.ot_trip)
      begin
        ot_q <= 1'b1; // [R10]
      end
      else if (cmp_q.ot_cool)
      begin
        ot_q <= 1'b0; // [R11]
      end
      if (start_run || ((state_q == ST_OFF) && fault_rise))
      begin
        buck_q <= cmp_q.mode_high; // [R12] [R13] [R17]
      end
      unique case (state_q)
        ST_OFF: state_q <= run_ok ? ST_RUN : ST_OFF; // [R9] [R11]
        ST_RUN: state_q <= run_ok ? ST_RUN : ST_OFF; // [R8] [R10]
      endcase
    end
  end

  // Role decode from the two role comparators, floating reads as master.
  // The decoded role is applied only at a wrap, so a change never truncates
  // the drive pulse of the period in progress.
  assign role_sel = cmp_q.role_hi ? ROLE_MASTER : // [R3]
                    cmp_q.role_lo ? ROLE_SLAVE : ROLE_SHIFT; // [R5] [R6]

  // Period timing and external synchronisation.
  // A slave restarts its period on each synchronised rising edge of the sync
  // pin and otherwise free-runs, so a lost external clock only slows it down
  // to its own programmed rate instead of stopping the converter.
  wire sync_rise = cmp_q.sync_in && !sync_prev_q;
  wire ext_start = (role_q == ROLE_SLAVE) ? sync_rise : // [R5]
                   (role_q == ROLE_SHIFT) ? (dly_run_q && (dly_q <= 12'h001)) : 1'b0; // [R6]
  wire wrap = (cnt_q >= period_q - 12'h001) || ext_start;
  wire [19:0] cnt_scaled = 20'(cnt_q) * 20'(PCT_FULL);
  wire [19:0] on_scaled = 20'(cmd_eff) * 20'(period_q);
  wire pwm_on = (cnt_scaled < on_scaled) && !peak_cut_q; // [R7] [R15]
  wire running = (state_q == ST_RUN) && run_ok;
  wire hs_d = running && (buck_q ? pwm_on : !pwm_on);
  wire ls_d = running && (buck_q ? (!pwm_on && !cmp_q.neg_valley) : pwm_on); // [R1]

  // Period counter, boundary updates, phase delay and peak cut-off.
  // The period is clamped when it is loaded, so a rate outside the legal
  // range is never used even for one period. A peak limit trip ends the
  // on time for the rest of the current period only.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      cnt_q <= 12'h000;
      period_q <= RST_PERIOD;
      role_q <= ROLE_MASTER;
      sync_prev_q <= 1'b0;
      dly_q <= 12'h000;
      dly_run_q <= 1'b0;
      peak_cut_q <= 1'b0;
    end
    else if (CE)
    begin
      sync_prev_q <= cmp_q.sync_in;
      if (wrap)
      begin
        cnt_q <= 12'h000;
        period_q <= clamp_period(rate_q); // [R2]
        role_q <= role_sel; // [R19]
        peak_cut_q <= 1'b0;
      end
      else
      begin
        cnt_q <= cnt_q + 12'h001;
        if (cmp_q.peak_lim)
        begin
          peak_cut_q <= 1'b1; // [R15]
        end
      end
      if (sync_rise && (role_q == ROLE_SHIFT))
      begin
        dly_q <= phase_q; // [R6]
        dly_run_q <= 1'b1;
      end
      else if (dly_run_q)
      begin
        dly_q <= dly_q - 12'h001;
        dly_run_q <= (dly_q > 12'h001);
      end
    end
  end

  // Drive and open-drain clock outputs, all from flip-flops.
  // The sync pin is pulled low during the second half of each period, which
  // gives equal high and low halves with the external pull-up.
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      drive_q <= '0;
      sync_oe_q <= 1'b0;
    end
    else if (CE)
    begin
      drive_q.high_side_drive <= hs_d; // [R8] [R10]
      drive_q.low_side_drive <= ls_d; // [R1] [R8] [R10]
      sync_oe_q <= (role_q == ROLE_MASTER) && (cnt_q >= (period_q >> 1)); // [R3] [R4]
    end
  end

  // Event capture: hardware set wins over a software clear in the same cycle.
  // Each event is a single-cycle pulse or a level; the sticky status keeps
  // it until software writes a one to the matching clear bit.
  wire [EVT_W-1:0] evt_set;
  assign evt_set[EVT_FAULT] = !cmp_q.fault_ok && fault_prev_q;
  assign evt_set[EVT_OVERTEMP] = cmp_q.ot_trip && !ot_q;
  assign evt_set[EVT_NEG] = running && buck_q && cmp_q.neg_valley;
  assign evt_set[EVT_PEAK] = running && cmp_q.peak_lim;
  assign evt_set[EVT_ROLE] = wrap && (role_sel != role_q);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      stat_q <= RST_EVT;
    end
    else if (CE)
    begin
      stat_q <= (stat_q & ~(wr_clr ? WB_DAT_I[EVT_W-1:0] : RST_EVT)) | evt_set;
    end
  end

  // Output assignments.
  // The sync data is always low: the pin is open drain and only its enable
  // toggles. The interrupt is a level that stays high while any enabled
  // status bit remains set.
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;
  assign DRIVE = drive_q;
  assign SYNC_O = 1'b0;
  assign SYNC_OE = sync_oe_q;
  assign SS_DISCHARGE = (state_q == ST_OFF); // [R8] [R10]
  assign BOOST_THRESH_SEL = !buck_q; // [R14]
  assign IRQ = |(stat_q & irq_en_q);

endmodule

// *** sim/bpwm_ctrl_sva.sv ***
/*
  Concurrent checks on the ports of the PWM clock and protection block.
  Assumes CE stays high and one clock domain with an asynchronous reset.
*/
module bpwm_ctrl_sva
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire bpwm_pkg::bpwm_cmp_s CMP_IN,
  input wire logic SYNC_O,
  input wire logic SYNC_OE,
  input wire bpwm_pkg::bpwm_drive_s DRIVE,
  input wire logic SS_DISCHARGE,
  input wire logic BOOST_THRESH_SEL
);
  timeunit 1ns;
  timeprecision 1ns;
  import bpwm_pkg::*;
  logic [11:0] nm_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Counts cycles since the role input last asked for master.
  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
      nm_q <= 12'h000;
    else if (CMP_IN.role_hi)
      nm_q <= 12'h000;
    else if (nm_q != 12'hfff)
      nm_q <= nm_q + 12'h001;
  // Reverse current held in buck, and a steady mode input up to the start of switching.
  sequence s_valley;
    (CMP_IN.neg_valley && !BOOST_THRESH_SEL)[*4];
  endsequence
  sequence s_enter;
    $stable(CMP_IN.mode_high)[*8] ##0 $fell(SS_DISCHARGE);
  endsequence
  AST_VALLEY_CUT: assert property (s_valley |-> !DRIVE.low_side_drive)
    else $error("low side on during reverse current");
  AST_SYNC_DATA: assert property (SYNC_O == 1'b0)
    else $error("sync data not low");
  AST_ROLE_INPUT: assert property (nm_q > 12'h834 |-> !SYNC_OE)
    else $error("sync pin still driven");
  AST_FAULT_OFF: assert property (!CMP_IN.fault_ok[*6] |-> DRIVE == 2'b00 && SS_DISCHARGE)
    else $error("drives active under fault");
  AST_OT_OFF: assert property (CMP_IN.ot_trip[*6] |-> DRIVE == 2'b00 && SS_DISCHARGE)
    else $error("drives active when hot");
  AST_RESTART: assert property ((CMP_IN.en_ok && CMP_IN.fault_ok && CMP_IN.ot_cool && !CMP_IN.ot_trip)[*6]
    |-> !SS_DISCHARGE)
    else $error("no restart");
  AST_MODE_PICK: assert property (s_enter |=> BOOST_THRESH_SEL == !CMP_IN.mode_high)
    else $error("wrong mode captured");
  AST_MODE_HOLD: assert property (!SS_DISCHARGE[*3] |-> $stable(BOOST_THRESH_SEL))
    else $error("mode changed while running");
  AST_NO_OVERLAP: assert property (!(DRIVE.high_side_drive && DRIVE.low_side_drive))
    else $error("both drives high");
endmodule

// *** sim/bpwm_bridge.sv ***
/*
  Half-bridge model: reports reverse current once the low-side switch conducts.
  Assumes the bench raises reverse to make the inductor current run backwards.
*/
module bpwm_bridge
(
  input wire logic clk,
  input wire logic rst,
  input wire bpwm_pkg::bpwm_drive_s drive,
  input wire logic reverse,
  output logic valley
);
  timeunit 1ns;
  timeprecision 1ns;
  // The valley comparator stays tripped until the current turns round again.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      valley <= 1'b0;
    else if (!reverse)
      valley <= 1'b0;
    else if (drive.low_side_drive)
      valley <= 1'b1;
endmodule

// *** sim/test_bidir_pwm_clock_and_protection.sv ***
/*
  Self-checking bench of the PWM clock and protection block with a half-bridge model.
  Assumes the package constants, a 100 MHz clock and a pulled-up sync pin.
*/
module test_bidir_pwm_clock_and_protection;
  timeunit 1ns;
  timeprecision 1ns;
  import bpwm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic rev = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dwr = 32'h0;
  logic [31:0] drd, rnd;
  logic ack, sync_o, sync_oe, ssd, bsel, irq, valley;
  logic ext_clk = 1'b1;
  logic ext_on = 1'b0;
  int ec = 0;
  bpwm_cmp_s c = 10'h318;
  bpwm_cmp_s cmp;
  bpwm_drive_s drv;
  logic [31:0] exq[$];
  int seed = 32'h14c5;
  int error_cnt = 0;
  int compares = 0;
  // Valley from the bridge model; the sync pin reads low while the block pulls it.
  assign cmp = {c[9:3], valley, c[1], ~sync_oe & ext_clk};
  always #5 clk = ~clk;
  // Clock of a neighbouring master, a little faster than our programmed rate.
  always @(posedge clk)
    if (ext_on)
    begin
      ec <= (ec == 899) ? 0 : ec + 1;
      ext_clk <= (ec < 450);
    end
  bpwm_ctrl i_bpwm_ctrl (.CLOCK(clk), .RST(rst), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dwr), .WB_DAT_O(drd), .WB_ACK_O(ack), .CMP_IN(cmp),
    .SYNC_O(sync_o), .SYNC_OE(sync_oe), .DRIVE(drv), .SS_DISCHARGE(ssd), .BOOST_THRESH_SEL(bsel), .IRQ(irq));
  bpwm_bridge i_bpwm_bridge (.clk(clk), .rst(rst), .drive(drv), .reverse(rev), .valley(valley));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    conclude;
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1)
      hang;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask
  // Waits a bounded time for the soft-start discharge output to reach a level.
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (ssd !== v && n++ < 40) @(posedge clk);
    if (ssd !== v)
      hang;
  endtask
  // Takes the oldest expected value whenever the slave answers a read.
  always @(posedge clk)
    if (ack === 1'b1 && !we)
      chk("read data", drd, exq.pop_front());
  // Main sequence: start, mode capture, reverse current, fault, heat, duty and role changes.
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (1010) @(posedge clk);
    rd(OFF_STATE, 32'h11);
    rd(8'h1c, 32'h0);
    wb(OFF_IRQ_EN, 1'b1, 32'h1f);
    c.fault_ok <= 1'b1;
    wt(1'b0);
    rd(OFF_STATE, 32'h16);
    rev <= 1'b1;
    repeat (20) @(posedge clk);
    rev <= 1'b0;
    rd(OFF_STATE, 32'h16);
    rd(OFF_IRQ_STAT, 32'h04);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(OFF_IRQ_CLR, 1'b1, 32'h1f);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    c.fault_ok <= 1'b0;
    wt(1'b1);
    c.mode_high <= 1'b0;
    rd(OFF_STATE, 32'h15);
    rd(OFF_IRQ_STAT, 32'h01);
    c.fault_ok <= 1'b1;
    wt(1'b0);
    rd(OFF_STATE, 32'h12);
    c.ot_cool <= 1'b0;
    c.ot_trip <= 1'b1;
    wt(1'b1);
    c.ot_trip <= 1'b0;
    repeat (10) @(posedge clk);
    rd(OFF_STATE, 32'h19);
    c.ot_cool <= 1'b1;
    wt(1'b0);
    rd(OFF_STATE, 32'h12);
    repeat (4)
    begin
      rnd = $random(seed);
      wb(OFF_DUTY, 1'b1, rnd);
      rd(OFF_DUTY, rnd & 32'h7f7f);
    end
    wb(OFF_IRQ_CLR, 1'b1, 32'h1f);
    c.role_hi <= 1'b0;
    c.role_lo <= 1'b1;
    ext_on <= 1'b1;
    repeat (2200) @(posedge clk);
    rd(OFF_STATE, 32'h22);
    c.role_lo <= 1'b0;
    repeat (2200) @(posedge clk);
    rd(OFF_STATE, 32'h42);
    rd(OFF_IRQ_STAT, 32'h10);
    repeat (3) @(posedge clk);
    conclude;
  end
endmodule
bind bpwm_ctrl bpwm_ctrl_sva u_sva (.CLOCK(CLOCK), .RST(RST), .CMP_IN(CMP_IN), .SYNC_O(SYNC_O),
  .SYNC_OE(SYNC_OE), .DRIVE(DRIVE), .SS_DISCHARGE(SS_DISCHARGE), .BOOST_THRESH_SEL(BOOST_THRESH_SEL));
